/* rcc_pkg.sv */
// Register map constants for the rate converter control bank.
// Assumes a 16-bit register port with word addresses.
package rcc_pkg;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [15:0] CONV2_LOW_RATE_CTRL       = 16'h0ef4;
   localparam logic [15:0] CONV2_CHANNEL_ENABLE_CTRL = 16'h0ef5;
   localparam logic [15:0] CONV3_HIGH_RATE_CTRL      = 16'h0ef6;
   localparam logic [15:0] CONV3_LOW_RATE_CTRL       = 16'h0ef7;
   localparam logic [15:0] CONV3_CHANNEL_ENABLE_CTRL = 16'h0ef8;

   // ----------------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------------
   localparam int RATE_SEL_MSB   = 14;
   localparam int RATE_SEL_LSB   = 11;
   localparam int INTERP_EN_MSB  = 15;
   localparam int INTERP_EN_LSB  = 12;
   localparam int DECIM_EN_MSB   = 9;
   localparam int DECIM_EN_LSB   = 6;
   localparam int NOTCH_EN_BIT   = 0;

   // Writable bits of each register kind
   localparam logic [15:0] RATE_REG_MASK = 16'h7800;
   localparam logic [15:0] ENA_REG_MASK  = 16'hf3c1;

   // ----------------------------------------------------------------------
   // Rate selector codes and reset values
   // ----------------------------------------------------------------------
   localparam logic [3:0] RATE_SYNC_1  = 4'h0;
   localparam logic [3:0] RATE_SYNC_2  = 4'h1;
   localparam logic [3:0] RATE_SYNC_3  = 4'h2;
   localparam logic [3:0] RATE_ASYNC_1 = 4'h8;
   localparam logic [3:0] RATE_ASYNC_2 = 4'h9;
   localparam logic [15:0] REG_RESET   = 16'h0000;

   typedef enum logic [4:0] {
      RCC_SYNC_1  = 5'h01,
      RCC_SYNC_2  = 5'h02,
      RCC_SYNC_3  = 5'h04,
      RCC_ASYNC_1 = 5'h08,
      RCC_ASYNC_2 = 5'h10
   } rcc_rate_t;

endpackage

/* rcc_reg_if.sv */
// Interface between the register bank and one control register.
// Assumes write strobe and data come from the host control port.
`timescale 1ns/10ps
interface rcc_reg_if;
   logic        wr;
   logic [15:0] wdata;
   logic [15:0] value;
   modport bank (output wr, output wdata, input value);
   modport field (input wr, input wdata, output value);
endinterface

/* rcc_field_reg.sv */
// One 16-bit control register with a mask of implemented bits.
// Assumes a synchronous active-high reset.
`timescale 1ns/10ps
module rcc_field_reg
   import rcc_pkg::*;
#(
   parameter logic [15:0] MASK = 16'hffff
) (
   input wire logic clk,
   input wire logic rst,
   rcc_reg_if.field port
);
   always_ff @(posedge clk) begin
      if (rst) begin
         port.value <= REG_RESET;          // [R3] [R11] [R12]
      end else if (port.wr) begin
         port.value <= port.wdata & MASK;  // [R13]
      end
   end
endmodule // rcc_field_reg

/* rcc_regs.sv */
// Control registers of the second and third sample rate converters.
// Assumes a synchronous word-addressed 16-bit host register port.
// Summary of operation
// [R1] High-rate selector codes 0000-0010 synchronous, 1000-1001 asynchronous.
// [R2] Low-rate selector uses the same five codes.
// [R3] Rate selectors sit at bits 14:11, four bits, reset 0000.
// [R4] Software writes only the five defined rate codes.
// [R5] Software keeps chosen rates within 8kHz to 192kHz.
// [R6] Software keeps high and low rates in one clock domain.
// [R7] Software clears decimation sources before changing the high rate.
// [R8] Software clears interpolation sources before changing the low rate.
// [R9] Bits 15:12 enable interpolation channels one to four.
// [R10] Bits 9:6 enable decimation channels one to four.
// [R11] Channel enables reset to 0; writing 1 enables the path.
// [R12] Bit 0 enables the notch filter, reset disabled.
// [R13] Unimplemented bits read zero and ignore writes.
`timescale 1ns/10ps
module rcc_regs
   import rcc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   output logic             reg_hit,
   output logic      [3:0]  conv2_low_rate_sel,
   output logic      [3:0]  conv3_high_rate_sel,
   output logic      [3:0]  conv3_low_rate_sel,
   output logic      [4:0]  conv2_low_rate_code,
   output logic      [4:0]  conv3_high_rate_code,
   output logic      [4:0]  conv3_low_rate_code,
   output logic      [3:0]  conv2_interp_en,
   output logic      [3:0]  conv2_decim_en,
   output logic             conv2_notch_filter_en,
   output logic      [3:0]  conv3_interp_en,
   output logic      [3:0]  conv3_decim_en,
   output logic             conv3_notch_filter_en
);

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   localparam logic [15:0] OFFS [5] = '{CONV2_LOW_RATE_CTRL,
      CONV2_CHANNEL_ENABLE_CTRL, CONV3_HIGH_RATE_CTRL,
      CONV3_LOW_RATE_CTRL, CONV3_CHANNEL_ENABLE_CTRL};
   localparam logic [15:0] MASKS [5] = '{RATE_REG_MASK, ENA_REG_MASK,
      RATE_REG_MASK, RATE_REG_MASK, ENA_REG_MASK};

   rcc_reg_if regs [5] ();
   wire logic [15:0] value [5];
   wire logic [4:0]  sel_hit;

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_reg
         assign sel_hit[g]      = (reg_addr == OFFS[g]);
         assign regs[g].wr      = reg_wr && sel_hit[g];
         assign regs[g].wdata   = reg_wdata;
         assign value[g]        = regs[g].value;
         rcc_field_reg #(.MASK(MASKS[g])) u_reg (
            .clk  (clk),
            .rst  (rst),
            .port (regs[g])
         );
      end
   endgenerate

   // Unmapped addresses read as zero
   wire logic [15:0] next_rdata = sel_hit[0] ? value[0] :
                                  sel_hit[1] ? value[1] :
                                  sel_hit[2] ? value[2] :
                                  sel_hit[3] ? value[3] :
                                  sel_hit[4] ? value[4] : 16'h0000; // [R13]

   // ----------------------------------------------------------------------
   // Rate code decode to one-hot, zero for reserved codes
   // ----------------------------------------------------------------------
   function automatic logic [4:0] decode_rate(input logic [3:0] c);
      logic [4:0] r;
      r = 5'h00;
      unique case (c)
         RATE_SYNC_1:  r = RCC_SYNC_1;   // [R1] [R2]
         RATE_SYNC_2:  r = RCC_SYNC_2;
         RATE_SYNC_3:  r = RCC_SYNC_3;
         RATE_ASYNC_1: r = RCC_ASYNC_1;
         RATE_ASYNC_2: r = RCC_ASYNC_2;
         default:      r = 5'h00;        // Reserved codes select nothing
      endcase
      return r;
   endfunction

   wire logic [3:0] c2l = value[0][RATE_SEL_MSB:RATE_SEL_LSB]; // [R3]
   wire logic [3:0] c3h = value[2][RATE_SEL_MSB:RATE_SEL_LSB];
   wire logic [3:0] c3l = value[3][RATE_SEL_MSB:RATE_SEL_LSB];

   // ----------------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata             <= 16'h0000;
         reg_hit               <= 1'b0;
         conv2_low_rate_sel    <= 4'h0;
         conv3_high_rate_sel   <= 4'h0;
         conv3_low_rate_sel    <= 4'h0;
         conv2_low_rate_code   <= RCC_SYNC_1;
         conv3_high_rate_code  <= RCC_SYNC_1;
         conv3_low_rate_code   <= RCC_SYNC_1;
         conv2_interp_en       <= 4'h0;
         conv2_decim_en        <= 4'h0;
         conv2_notch_filter_en <= 1'b0;
         conv3_interp_en       <= 4'h0;
         conv3_decim_en        <= 4'h0;
         conv3_notch_filter_en <= 1'b0;
      end else begin
         reg_rdata             <= reg_rd ? next_rdata : 16'h0000;
         reg_hit               <= (reg_rd || reg_wr) && (|sel_hit);
         conv2_low_rate_sel    <= c2l;
         conv3_high_rate_sel   <= c3h;
         conv3_low_rate_sel    <= c3l;
         conv2_low_rate_code   <= decode_rate(c2l);
         conv3_high_rate_code  <= decode_rate(c3h);
         conv3_low_rate_code   <= decode_rate(c3l);
         conv2_interp_en <= value[1][INTERP_EN_MSB:INTERP_EN_LSB]; // [R9]
         conv2_decim_en  <= value[1][DECIM_EN_MSB:DECIM_EN_LSB];   // [R10]
         conv2_notch_filter_en <= value[1][NOTCH_EN_BIT];          // [R12]
         conv3_interp_en <= value[4][INTERP_EN_MSB:INTERP_EN_LSB]; // [R9]
         conv3_decim_en  <= value[4][DECIM_EN_MSB:DECIM_EN_LSB];   // [R10]
         conv3_notch_filter_en <= value[4][NOTCH_EN_BIT];          // [R12]
      end
   end

endmodule // rcc_regs

/* rcc_regs_asserts.sv */
// Port assertions for the rate converter control bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module rcc_regs_asserts
   import rcc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_hit,
   input wire logic [3:0]  conv2_low_rate_sel,
   input wire logic [3:0]  conv3_low_rate_sel,
   input wire logic [4:0]  conv2_low_rate_code,
   input wire logic [4:0]  conv3_high_rate_code,
   input wire logic [4:0]  conv3_low_rate_code,
   input wire logic [3:0]  conv2_interp_en,
   input wire logic [3:0]  conv3_decim_en,
   input wire logic        conv2_notch_filter_en,
   input wire logic        conv3_notch_filter_en,
   input wire logic [3:0]  conv3_interp_en,
   input wire logic [3:0]  conv3_high_rate_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic mapped = reg_addr >= 16'h0ef4 && reg_addr <= 16'h0ef8;
   sequence wr_c2e; reg_wr && reg_addr == CONV2_CHANNEL_ENABLE_CTRL; endsequence
   sequence wr_c3e; reg_wr && reg_addr == CONV3_CHANNEL_ENABLE_CTRL; endsequence
   interp_write_a: assert property (wr_c2e |-> ##2
      conv2_interp_en == $past(reg_wdata[15:12], 2)) else $error("interp");
   decim_write_a: assert property (wr_c3e |-> ##2
      conv3_decim_en == $past(reg_wdata[9:6], 2)) else $error("decim");
   notch_write_a: assert property (wr_c3e |-> ##2
      conv3_notch_filter_en == $past(reg_wdata[0], 2)) else $error("notch");
   async_code_a: assert property (conv3_high_rate_sel == RATE_ASYNC_2
      |-> conv3_high_rate_code == 5'h10) else $error("async decode");
   sync_code_a: assert property (conv2_low_rate_sel == RATE_SYNC_3
      |-> conv2_low_rate_code == 5'h04) else $error("sync decode");
   rate_bits_a: assert property (reg_rd && reg_addr == 16'h0ef7 |=>
      reg_rdata == {1'b0, conv3_low_rate_sel, 11'h000}) else $error("rate");
   unmapped_read_a: assert property (reg_rd && !mapped |=>
      reg_rdata == 16'h0000 && !reg_hit) else $error("unmapped");
   reset_vals_a: assert property ($fell(rst) |-> conv3_interp_en == 4'h0
      && conv3_low_rate_code == 5'h01 && !conv2_notch_filter_en)
      else $error("reset");
endmodule // rcc_regs_asserts
bind rcc_regs rcc_regs_asserts chk_i (.clk(clk), .rst(rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_hit(reg_hit),
   .conv2_low_rate_sel(conv2_low_rate_sel),
   .conv3_low_rate_sel(conv3_low_rate_sel),
   .conv2_low_rate_code(conv2_low_rate_code),
   .conv3_high_rate_code(conv3_high_rate_code),
   .conv3_low_rate_code(conv3_low_rate_code),
   .conv2_interp_en(conv2_interp_en), .conv3_decim_en(conv3_decim_en),
   .conv2_notch_filter_en(conv2_notch_filter_en),
   .conv3_notch_filter_en(conv3_notch_filter_en),
   .conv3_interp_en(conv3_interp_en),
   .conv3_high_rate_sel(conv3_high_rate_sel));

/* rate_converter_control_regs_tb_top.sv */
// Self-checking bench for the rate converter control bank.
// Assumes the bank answers reads one cycle after the strobe.
`timescale 1ns/10ps
module rate_converter_control_regs_tb_top;
   import rcc_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        rd_d = 1'b0, reg_hit;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, d;
   logic [15:0] exp_q[$];
   logic [4:0]  c3h_code;
   logic [3:0]  i2_en, d3_en, d2_en, i3_en, c2l_sel, c3h_sel, c3l_sel;
   logic [4:0]  c2l_code, c3l_code;
   logic        n2_en, n3_en;
   logic        hit_q[$];
   integer      fails = 0, n_tests = 0, seed = 50, i;
   logic [15:0] maps [5] = '{16'h0ef4, 16'h0ef5, 16'h0ef6, 16'h0ef7, 16'h0ef8};
   logic [15:0] masks [5] = '{RATE_REG_MASK, ENA_REG_MASK, RATE_REG_MASK,
                              RATE_REG_MASK, ENA_REG_MASK};
   // Only the five legal codes, all within the supported rate span
   logic [3:0]  codes [5] = '{RATE_SYNC_1, RATE_SYNC_2, RATE_SYNC_3,
                              RATE_ASYNC_1, RATE_ASYNC_2};
   initial forever #12.5 clk = ~clk;
   rcc_regs dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .conv2_low_rate_sel(c2l_sel),
      .conv3_high_rate_sel(c3h_sel), .conv3_low_rate_sel(c3l_sel),
      .conv2_low_rate_code(c2l_code), .conv3_high_rate_code(c3h_code),
      .conv3_low_rate_code(c3l_code), .conv2_interp_en(i2_en),
      .conv2_decim_en(d2_en), .conv2_notch_filter_en(n2_en),
      .conv3_interp_en(i3_en), .conv3_decim_en(d3_en),
      .conv3_notch_filter_en(n3_en));
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a; exp_q.push_back(e);
      hit_q.push_back(a >= CONV2_LOW_RATE_CTRL &&
                      a <= CONV3_CHANNEL_ENABLE_CTRL);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Read data stands one cycle only, so it is taken the edge after strobe
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         chk(reg_rdata, exp_q.pop_front());
         chk(16'(reg_hit), 16'(hit_q.pop_front()));
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) rd(maps[i], REG_RESET);
      $display("reset values done");
      for (i = 0; i < 5; i++) begin
         d = 16'($random(seed));
         // Legal synchronous codes only, so both conv3 rates share a domain
         d[14:11] = codes[i % 3];
         wr(maps[i], d);
         rd(maps[i], d & masks[i]);
      end
      wr(16'h0ef9, 16'hffff);
      rd(16'h0ef9, 16'h0000);
      rd(16'h0ef3, 16'h0000);
      $display("access done");
      // Source selectors live outside this bank and stay cleared here
      for (i = 0; i < 5; i++) begin
         wr(CONV2_LOW_RATE_CTRL, {1'b0, codes[i], 11'h000});
         wr(CONV3_HIGH_RATE_CTRL, {1'b0, codes[i], 11'h000});
         wr(CONV3_LOW_RATE_CTRL, {1'b0, codes[i], 11'h000});
         repeat (2) @(posedge clk);
         chk(16'(c3h_code), 16'h0001 << i);
         chk(16'(c2l_code), 16'h0001 << i);
         chk(16'(c3l_code), 16'h0001 << i);
         chk(16'(c3h_sel), 16'(codes[i]));
         chk(16'(c2l_sel), 16'(codes[i]));
         chk(16'(c3l_sel), 16'(codes[i]));
      end
      $display("rate codes done");
      wr(CONV2_CHANNEL_ENABLE_CTRL, 16'h8001);
      wr(CONV3_CHANNEL_ENABLE_CTRL, 16'h0240);
      repeat (2) @(posedge clk);
      chk(16'(i2_en), 16'h0008);
      chk(16'(d3_en), 16'h0009);
      chk(16'(d2_en), 16'h0000);
      chk(16'(i3_en), 16'h0000);
      chk(16'(n2_en), 16'h0001);
      chk(16'(n3_en), 16'h0000);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) rd(maps[i], REG_RESET);
      chk(16'(c3h_code), 16'h0001);
      chk(16'(i2_en), 16'h0000);
      chk(16'(n2_en), 16'h0000);
      $display("enables and reset done");
      end_sim();
   end
endmodule // rate_converter_control_regs_tb_top
